// ==== fpfs_defines.svh ====
// Purpose: Shared constants of the fan PWM fault supervisor.
// Assumes: One 125 MHz clock; all timing derived from it.
// Notes:   Definitions only; included by bare name.
`ifndef FPFS_DEFINES_SVH
`define FPFS_DEFINES_SVH

`define FPFS_CLK_HZ          125000000
`define FPFS_CLK_PERIOD_NS   8
`define FPFS_PWM_HZ          30
`define FPFS_RAMP_STEPS      256
// Clock cycles per ramp step; one PWM period is RAMP_STEPS steps.
`define FPFS_STEP_CYC        (`FPFS_CLK_HZ / (`FPFS_PWM_HZ * `FPFS_RAMP_STEPS))

`define FPFS_MISS_PERIODS    32
`define FPFS_START_PERIODS   32
`define FPFS_DIAG_PERIODS    3

// Sense blanking after each drive turn-on edge, a least time.
`define FPFS_BLANK_NS        20000
`define FPFS_BLANK_CYC       ((`FPFS_BLANK_NS + `FPFS_CLK_PERIOD_NS - 1) / `FPFS_CLK_PERIOD_NS)

// Bit positions inside the synchronised comparator vector.
`define FPFS_SYN_SHDN        0
`define FPFS_SYN_OVERTEMP    1
`define FPFS_SYN_SENSE       2
`define FPFS_SYN_WIDTH       3

`endif

// ==== fpfs_pkg.sv ====
// Purpose: Types of the fan PWM fault supervisor.
// Assumes: fpfs_defines.svh supplies the widths.
// Notes:   States are Gray coded along the start, normal, retry path.
`include "fpfs_defines.svh"

package fpfs_pkg;

  typedef enum logic [2:0] {
    FPFS_SHUTDOWN = 3'h0,
    FPFS_START1   = 3'h1,
    FPFS_START2   = 3'h3,
    FPFS_NORMAL   = 3'h2,
    FPFS_DIAG     = 3'h6,
    FPFS_RETRY    = 3'h7,
    FPFS_FAULT    = 3'h5
  } fpfs_mode_t;

  typedef struct packed {
    logic [`FPFS_SYN_WIDTH-1:0] meta;
    logic [`FPFS_SYN_WIDTH-1:0] stable;
  } fpfs_sync_t;

  typedef struct packed {
    fpfs_mode_t  mode;
    logic [15:0] step_cnt;
    logic [7:0]  ramp;
    logic [5:0]  per_cnt;
    logic [11:0] blank_cnt;
    logic [7:0]  duty;
    logic        sense_d;
    logic        drive;
    logic        fault_n;
  } fpfs_state_t;

endpackage

// ==== fpfs_sync.sv ====
// Purpose: Two-flop synchroniser for the comparator indications.
// Assumes: Inputs may change at any time relative to clock.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
`include "fpfs_defines.svh"

module fpfs_sync
  import fpfs_pkg::*;
(
  input  wire logic                       clock,   // System clock.
  input  wire logic                       rst_n,   // Synchronised reset, active low.
  input  wire logic                       clk_en,  // Freezes the stages while low.
  input  wire logic [`FPFS_SYN_WIDTH-1:0] async_in, // Raw comparator levels.
  output logic      [`FPFS_SYN_WIDTH-1:0] sync_out  // Levels in the clock domain.
);

  // Reset reads as shutdown requested, so no start fires before the real level arrives.
  localparam logic [`FPFS_SYN_WIDTH-1:0] SYN_RESET = {{(`FPFS_SYN_WIDTH-1){1'b0}}, 1'b1} << `FPFS_SYN_SHDN;

  fpfs_sync_t s_r;
  fpfs_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (clk_en) begin
      s_nxt.meta   = async_in;
      s_nxt.stable = s_r.meta;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r.meta   <= SYN_RESET;
      s_r.stable <= SYN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stable;

endmodule

// ==== fpfs_top.sv ====
// Purpose: Sequencer and PWM generator of a supervised fan drive.
// Assumes: Demand words are synchronous to clock; comparator levels are not.
// Notes:   The PWM period is the timebase for every window except the sense blank window.
// What this block does
// - Sense pulses near a drive turn-on edge are blanked before detection.
// - Thirty-two periods without a pulse start a three-period full-on window.
// - No pulse in that window triggers the start-up timer again.
// - Timeout after that retry stops drive and latches fault low.
// - Power-up out of shutdown drives full on for thirty-two periods.
// - A pulse in start-up enters normal; else one more start-up, then fault.
// - Each normal loop pass clears the missing pulse counter on a pulse.
// - Normal operation exits only to shutdown or the diagnostic window.
// - Shutdown forces zero duty, fault inactive, and resumes like power-up.
// - Outside shutdown and fan fault, fault output follows the over-temperature comparator level.
// - Over-temperature alone never stops the drive or latches anything.
// - Duty each period follows the larger of the two demands.
// - A pulse in the diagnostic window returns to normal; else retry.
// - Fan fault holds fault low and drive off.
// - Fan fault is left only by shutdown and release, then power-up.
// - Any shutdown entry, even brief, resets and clears a latched fault.
// - Shutdown resets mode, step, ramp, period count and duty, and keeps the fault output inactive.
// - All windows but the blank window are counted in PWM ramp periods; blanking counts clocks.
`timescale 1ns/1ps
`include "fpfs_defines.svh"

module fpfs_top
  import fpfs_pkg::*;
#(
  parameter int STEP_CYC = `FPFS_STEP_CYC  // Clock cycles per ramp step.
)
(
  input  wire logic       clock,                 // 125 MHz system clock.
  input  wire logic       rst_n,                 // Asynchronous reset, active low.
  input  wire logic       clk_en,                // Freezes all state while low.
  input  wire logic [7:0] temp_demand_in,        // Temperature duty demand.
  input  wire logic [7:0] min_speed_demand_in,   // Minimum-speed duty demand.
  input  wire logic       min_speed_shutdown_in, // High while below shutdown threshold.
  input  wire logic       overtemp_in,           // High while above overtemp threshold.
  input  wire logic       sense_pulse_in,        // Commutation sense pulse level.
  output logic            fan_drive_out,         // Fan switch drive, high is on.
  output logic            fault_n_out,           // Fault output, active low.
  output logic      [2:0] seq_state_out,         // Current sequencer state code.
  output logic            period_tick_out        // One-cycle pulse at PWM period end.
);

  localparam logic [15:0] STEP_LAST  = 16'(STEP_CYC - 1);
  localparam logic [11:0] BLANK_LOAD = 12'(`FPFS_BLANK_CYC);
  localparam logic [5:0]  MISS_LAST  = 6'(`FPFS_MISS_PERIODS - 1);
  localparam logic [5:0]  START_LAST = 6'(`FPFS_START_PERIODS - 1);
  localparam logic [5:0]  DIAG_LAST  = 6'(`FPFS_DIAG_PERIODS - 1);

  // Drive is held fully on in every timed recovery state.
  function automatic logic forced_on(input fpfs_mode_t m);
    forced_on = (m == FPFS_START1) || (m == FPFS_START2) ||
                (m == FPFS_DIAG)   || (m == FPFS_RETRY);
  endfunction

  // Last period index of the window that a state times.
  function automatic logic [5:0] window_last(input fpfs_mode_t m);
    case (m)
      FPFS_DIAG:   window_last = DIAG_LAST;
      FPFS_NORMAL: window_last = MISS_LAST;
      default:     window_last = START_LAST;
    endcase
  endfunction

  logic [1:0]                 rst_sync_r;
  logic                       rst_int_n;
  logic [`FPFS_SYN_WIDTH-1:0] raw_vec;
  logic [`FPFS_SYN_WIDTH-1:0] syn_vec;
  fpfs_state_t                s_r;
  fpfs_state_t                s_nxt;
  logic                       tick;

  // Reset is asserted at once and released two edges later.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_r[1];

  assign raw_vec[`FPFS_SYN_SHDN]     = min_speed_shutdown_in;
  assign raw_vec[`FPFS_SYN_OVERTEMP] = overtemp_in;
  assign raw_vec[`FPFS_SYN_SENSE]    = sense_pulse_in;

  fpfs_sync u_sync (
    .clock    (clock),
    .rst_n    (rst_int_n),
    .clk_en   (clk_en),
    .async_in (raw_vec),
    .sync_out (syn_vec)
  );

  always_comb begin
    logic       shdn;
    logic       hot;
    logic       rise;
    logic       pulse;
    logic       timeout;
    logic       restart;
    logic [8:0] duty9;
    shdn    = syn_vec[`FPFS_SYN_SHDN];
    hot     = syn_vec[`FPFS_SYN_OVERTEMP];
    rise    = 1'b0;
    pulse   = 1'b0;
    timeout = 1'b0;
    restart = 1'b0;
    duty9   = 9'h000;
    tick    = 1'b0;
    s_nxt   = s_r;

    if (clk_en) begin
      // Ramp timebase: one period is 256 steps of STEP_CYC clocks.
      if (s_r.step_cnt == STEP_LAST) begin
        s_nxt.step_cnt = 16'h0000;
        s_nxt.ramp     = s_r.ramp + 8'h01;
        tick           = (s_r.ramp == 8'hff);
      end else begin
        s_nxt.step_cnt = s_r.step_cnt + 16'h0001;
      end

      // Duty is sampled once per period so a period never tears.
      if (tick) begin
        s_nxt.duty = (temp_demand_in > min_speed_demand_in) ?
                     temp_demand_in : min_speed_demand_in;
      end

      // Only rising sense edges outside the blank window count.
      s_nxt.sense_d = syn_vec[`FPFS_SYN_SENSE];
      rise  = syn_vec[`FPFS_SYN_SENSE] & ~s_r.sense_d;
      pulse = rise && (s_r.blank_cnt == 12'h000);

      if (tick) begin
        if (s_r.per_cnt == window_last(s_r.mode)) begin
          timeout = 1'b1;
        end else begin
          s_nxt.per_cnt = s_r.per_cnt + 6'h01;
        end
      end

      case (s_r.mode)
        FPFS_SHUTDOWN: begin
          if (!shdn) begin
            s_nxt.mode = FPFS_START1;
            restart    = 1'b1;
          end
        end
        FPFS_START1: begin
          if (pulse) begin
            s_nxt.mode    = FPFS_NORMAL;
            s_nxt.per_cnt = 6'h00;
          end else if (timeout) begin
            s_nxt.mode = FPFS_START2;
            restart    = 1'b1;
          end
        end
        FPFS_START2: begin
          if (pulse) begin
            s_nxt.mode    = FPFS_NORMAL;
            s_nxt.per_cnt = 6'h00;
          end else if (timeout) begin
            s_nxt.mode = FPFS_FAULT;
          end
        end
        FPFS_NORMAL: begin
          if (pulse) begin
            s_nxt.per_cnt = 6'h00;
          end else if (timeout) begin
            s_nxt.mode = FPFS_DIAG;
            restart    = 1'b1;
          end
        end
        FPFS_DIAG: begin
          if (pulse) begin
            s_nxt.mode    = FPFS_NORMAL;
            s_nxt.per_cnt = 6'h00;
          end else if (timeout) begin
            s_nxt.mode = FPFS_RETRY;
            restart    = 1'b1;
          end
        end
        FPFS_RETRY: begin
          if (pulse) begin
            s_nxt.mode    = FPFS_NORMAL;
            s_nxt.per_cnt = 6'h00;
          end else if (timeout) begin
            s_nxt.mode = FPFS_FAULT;
          end
        end
        FPFS_FAULT: begin
          s_nxt.per_cnt = 6'h00;
        end
        default: begin
          s_nxt.mode = FPFS_SHUTDOWN;
        end
      endcase

      // A full-on window restarts the ramp so it spans whole periods.
      if (restart) begin
        s_nxt.step_cnt = 16'h0000;
        s_nxt.ramp     = 8'h00;
        s_nxt.per_cnt  = 6'h00;
      end

      // Shutdown outranks every state, including a latched fault.
      if (shdn) begin
        s_nxt.mode     = FPFS_SHUTDOWN;
        s_nxt.step_cnt = 16'h0000;
        s_nxt.ramp     = 8'h00;
        s_nxt.per_cnt  = 6'h00;
        s_nxt.duty     = 8'h00;
      end

      if (forced_on(s_nxt.mode)) begin
        s_nxt.drive = 1'b1;
      end else if (s_nxt.mode == FPFS_NORMAL) begin
        duty9 = (s_nxt.duty == 8'hff) ? 9'h100 : {1'b0, s_nxt.duty};
        s_nxt.drive = ({1'b0, s_nxt.ramp} < duty9);
      end else begin
        s_nxt.drive = 1'b0;
      end

      // The blank window opens on each turn-on edge of the drive.
      if (s_nxt.drive && !s_r.drive) begin
        s_nxt.blank_cnt = BLANK_LOAD;
      end else if (s_r.blank_cnt != 12'h000) begin
        s_nxt.blank_cnt = s_r.blank_cnt - 12'h001;
      end

      // Over-temperature only flags; the drive above is untouched by it.
      case (s_nxt.mode)
        FPFS_SHUTDOWN: s_nxt.fault_n = 1'b1;
        FPFS_FAULT:    s_nxt.fault_n = 1'b0;
        default:       s_nxt.fault_n = ~hot;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_r         <= '0;
      s_r.mode    <= FPFS_SHUTDOWN;
      s_r.fault_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fan_drive_out   = s_r.drive;
  assign fault_n_out     = s_r.fault_n;
  assign seq_state_out   = s_r.mode;
  assign period_tick_out = tick;

endmodule

// ==== fpfs_fan_model.sv ====
// Purpose: Behavioural fan that gives commutation pulses on its sense line.
// Assumes: A rotor commutates only after the switch has been on a while.
// Notes:   A stalled fan never pulses; the line idles low.
`timescale 1ns/1ps
module fpfs_fan_model (
  input  wire logic clock,   // System clock.
  input  wire logic drive,   // Switch drive, high is on.
  input  wire logic stalled, // High holds the rotor still.
  output logic      sense    // Sense comparator level.
);
  int on_cnt = 0;
  // Commutation needs current, so the count restarts whenever drive drops.
  always @(posedge clock) begin
    on_cnt <= (drive && !stalled) ? on_cnt + 1 : 0;
    sense  <= (on_cnt % 3000) inside {[2990:2999]};
  end
endmodule

// ==== fpfs_top_asserts.sv ====
// Purpose: Port checker of the fan PWM fault supervisor.
// Assumes: clk_en stays high while windows are timed.
// Notes:   dwell_r counts cycles seen in the present state.
`timescale 1ns/1ps
module fpfs_top_asserts #(
  parameter int STEP_CYC = 2 // Clock cycles per ramp step.
) (
  input wire logic       clock,                 // System clock.
  input wire logic       rst_n,                 // Reset, active low.
  input wire logic       clk_en,                // Clock enable.
  input wire logic       min_speed_shutdown_in, // Shutdown request.
  input wire logic       overtemp_in,           // Over-temperature level.
  input wire logic       fan_drive_out,         // Fan drive.
  input wire logic       fault_n_out,           // Fault, active low.
  input wire logic [2:0] seq_state_out          // Sequencer state.
);
  localparam int PER = 256 * STEP_CYC;
  logic [2:0]  prev_r;
  logic [31:0] dwell_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_r  <= 3'h0;
      dwell_r <= 32'h0;
    end else begin
      prev_r  <= seq_state_out;
      dwell_r <= (seq_state_out == prev_r) ? dwell_r + 32'h1 : 32'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  fault_hold_a: assert property (seq_state_out == 3'h5 |-> !fan_drive_out && !fault_n_out)
    else $error("fan fault state drives or frees fault");
  shdn_quiet_a: assert property (seq_state_out == 3'h0 |-> !fan_drive_out && fault_n_out)
    else $error("shutdown state drives or flags fault");
  shdn_entry_a: assert property ((clk_en && min_speed_shutdown_in) [*3] |=> seq_state_out == 3'h0)
    else $error("shutdown request not honoured");
  window_on_a: assert property (seq_state_out inside {3'h1, 3'h3, 3'h6, 3'h7} |-> fan_drive_out)
    else $error("drive off in a full-on window");
  ot_set_a: assert property ((clk_en && overtemp_in && seq_state_out inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7}) [*4] |-> !fault_n_out)
    else $error("overtemp not flagged");
  ot_clear_a: assert property ((clk_en && !overtemp_in && seq_state_out inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7}) [*4] |-> fault_n_out)
    else $error("fault not released");
  fault_entry_a: assert property (seq_state_out == 3'h5 && prev_r != 3'h5 |-> prev_r inside {3'h3, 3'h7})
    else $error("fan fault entered from wrong state");
  normal_exit_a: assert property (prev_r == 3'h2 && seq_state_out != 3'h2 |-> seq_state_out inside {3'h0, 3'h6})
    else $error("normal left to wrong state");
  diag_len_a: assert property (prev_r == 3'h6 && seq_state_out == 3'h7 |-> dwell_r == 32'(3 * PER))
    else $error("diagnostic window length wrong");
  start_len_a: assert property (prev_r == 3'h1 && seq_state_out == 3'h3 |-> dwell_r == 32'(32 * PER))
    else $error("start window length wrong");
  retry_len_a: assert property (prev_r == 3'h7 && seq_state_out == 3'h5 |-> dwell_r == 32'(32 * PER))
    else $error("retry window length wrong");
endmodule
bind fpfs_top fpfs_top_asserts #(.STEP_CYC(STEP_CYC)) u_asserts (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .min_speed_shutdown_in(min_speed_shutdown_in),
  .overtemp_in(overtemp_in), .fan_drive_out(fan_drive_out), .fault_n_out(fault_n_out),
  .seq_state_out(seq_state_out));

// ==== fpfs_top_tb.sv ====
// Purpose: Self-checking bench of the fan PWM fault supervisor.
// Assumes: STEP_CYC of 2 gives a 512-clock PWM period.
// Notes:   Demand 8'hff keeps drive on so fan pulses clear blanking.
`timescale 1ns/1ps
module fpfs_top_tb;
  localparam int STEP = 2;
  localparam int PER  = 256 * STEP;
  logic       clock   = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] temp_d  = 8'hff;
  logic [7:0] min_d   = 8'h00;
  logic       shdn    = 1'b0;
  logic       otemp   = 1'b0;
  logic       stalled = 1'b0;
  logic       en      = 1'b1;
  logic       sense;
  logic       drive;
  logic       fault_n;
  logic       tick;
  logic [2:0] seq;
  int         bad_count    = 0;
  int         total_checks = 0;
  int         cycles       = 0;
  fpfs_top #(.STEP_CYC(STEP)) u_dut (.clock(clock), .rst_n(rst_n), .clk_en(en),
    .temp_demand_in(temp_d), .min_speed_demand_in(min_d), .min_speed_shutdown_in(shdn),
    .overtemp_in(otemp), .sense_pulse_in(sense), .fan_drive_out(drive), .fault_n_out(fault_n),
    .seq_state_out(seq), .period_tick_out(tick));
  fpfs_fan_model u_fan (.clock(clock), .drive(drive), .stalled(stalled), .sense(sense));
  initial forever #4 clock = ~clock;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The run needs about 73000 cycles; a hang is cut off well past that.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_seq(logic [2:0] code, int limit);
    int n;
    n = 0;
    while (seq !== code && n < limit) begin
      @(negedge clock);
      n++;
    end
    chk("state", {13'h0, code}, {13'h0, seq});
  endtask
  task automatic pins(logic [2:0] s, logic d, logic f);
    chk("state", {13'h0, s}, {13'h0, seq});
    chk("drive", {15'h0, d}, {15'h0, drive});
    chk("fault_n", {15'h0, f}, {15'h0, fault_n});
  endtask
  task automatic set_in(logic sd, logic ot, logic st);
    @(posedge clock);
    shdn    <= sd;
    otemp   <= ot;
    stalled <= st;
  endtask
  task automatic t_powerup();
    wait_seq(3'h1, 10);
    pins(3'h1, 1'b1, 1'b1);
    wait_seq(3'h2, 8 * PER);
  endtask
  task automatic t_duty();
    int n;
    n = 0;
    @(posedge clock);
    temp_d <= 8'h30;
    min_d  <= 8'h90;
    do @(negedge clock); while (tick !== 1'b1);
    do begin
      @(negedge clock);
      n++;
    end while (tick !== 1'b1);
    chk("tick_period", 16'(PER), n[15:0]);
    n = 0;
    repeat (PER) begin
      @(negedge clock);
      if (drive === 1'b1) n++;
    end
    chk("high_cycles", 16'(144 * STEP), n[15:0]);
    @(posedge clock);
    temp_d <= 8'hff;
    min_d  <= 8'h00;
  endtask
  task automatic t_overtemp();
    set_in(1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge clock);
    pins(3'h2, 1'b1, 1'b0);
    set_in(1'b0, 1'b0, 1'b0);
    repeat (6) @(negedge clock);
    pins(3'h2, 1'b1, 1'b1);
  endtask
  task automatic t_freeze();
    int hits;
    hits = 0;
    @(posedge clock);
    en <= 1'b0;
    repeat (PER) begin
      @(negedge clock);
      if (tick !== 1'b0 || drive !== 1'b1) hits++;
    end
    chk("frozen_moves", 16'h0000, hits[15:0]);
    pins(3'h2, 1'b1, 1'b1);
    @(posedge clock);
    en <= 1'b1;
  endtask
  task automatic t_stall();
    set_in(1'b0, 1'b0, 1'b1);
    wait_seq(3'h6, 34 * PER);
    pins(3'h6, 1'b1, 1'b1);
    wait_seq(3'h7, 3 * PER + 8);
    wait_seq(3'h5, 32 * PER + 8);
    repeat (50) @(negedge clock);
    pins(3'h5, 1'b0, 1'b0);
  endtask
  task automatic t_restart();
    set_in(1'b1, 1'b0, 1'b1);
    repeat (5) @(posedge clock);
    shdn <= 1'b0;
    @(negedge clock);
    pins(3'h0, 1'b0, 1'b1);
    wait_seq(3'h1, 10);
    wait_seq(3'h3, 32 * PER + 8);
    wait_seq(3'h5, 32 * PER + 8);
  endtask
  task automatic t_final();
    set_in(1'b1, 1'b1, 1'b0);
    repeat (5) @(negedge clock);
    pins(3'h0, 1'b0, 1'b1);
    set_in(1'b0, 1'b0, 1'b0);
    wait_seq(3'h1, 10);
    wait_seq(3'h2, 8 * PER);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_powerup();
    t_duty();
    t_overtemp();
    t_freeze();
    t_stall();
    t_restart();
    t_final();
    wrap_up();
  end
endmodule
